// [verilog/aicc_pkg.sv]
// Package of constants and types for the input configuration control block
// Notes on behaviour
// R1: A write with bits 11 and 10 both zero addresses the first control word.
// R2: Bit 0 picks the reference: zero on-chip, one external.
// R3: Bit 1 zero: continuous, one result stored per falling sample clock edge.
// R4: Bit 1 one: falling edge of the start pin holds and converts selected inputs.
// R5: In single-shot mode the ready flag rises only once the trigger is met.
// R6: Bit 2 zero keeps the converter running, one powers it down.
// R7: Writes, reads and FIFO readout still work while powered down.
// R8: Bits 7..3 choose single-ended, differential or autoscan; other codes reserved.
// R9: Bits 9..8 substitute upper, midpoint or lower reference for the input.
// R10: Reset value is all zero except the low differential-count bit.
// R11: The host puts ten value bits low and two address bits high.
// R12: Trigger is met when written results reach the trigger level.
// R13: The host never writes a reserved input arrangement code.
package aicc_pkg;
   localparam int DATA_W = 12;
   localparam int CFG_W = 10;
   localparam logic [1:0] ADDR_CW0 = 2'h0;
   localparam int ADDR_LO = 10;
   localparam int VREF_POS = 0;
   localparam int MODE_POS = 1;
   localparam int PD_POS = 2;
   localparam int ARR_LO = 3;
   localparam int TEST_LO = 8;
   localparam logic [9:0] CW0_RESET = 10'h020;
   localparam logic [4:0] ARR_POS_SE = 5'h00;
   localparam logic [4:0] ARR_NEG_SE = 5'h01;
   localparam logic [4:0] ARR_DIFF = 5'h04;
   localparam logic [4:0] ARR_SCAN = 5'h11;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] TRIG_RESET = 4'h1;

   typedef enum logic [1:0] {SRC_NORMAL, SRC_UPPER, SRC_MID, SRC_LOWER} aicc_src_t;

   typedef struct packed {
      logic [1:0] test_sel;
      logic [4:0] arrangement;
      logic power_down_bit;
      logic single_mode;
      logic ext_ref;
   } aicc_cfg_t;

   typedef struct packed {
      logic chan;
      logic [11:0] value;
   } aicc_sample_t;
endpackage

// [verilog/aicc_fifo.sv]
// Result FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module aicc_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg;
   logic push, pop;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // aicc_fifo
`default_nettype wire

// [verilog/aicc_ctrl.sv]
// Input configuration control: control word zero, conversion pacing, result FIFO
`timescale 1ns/10ps
`default_nettype none
module aicc_ctrl #(
   parameter int DEPTH = aicc_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Parallel port write
   input wire logic wr_strobe,
   input wire logic [11:0] wr_data,
   // Parallel port read
   input wire logic cfg_rd,
   output logic [9:0] cfg_rd_data,
   // Trigger level from the second control word
   input wire logic [3:0] trig_level,
   input wire logic fifo_flush,
   // Converter pin and converter core
   input wire logic sample_clock_in,
   input wire logic [11:0] conv_pos,
   input wire logic [11:0] conv_neg,
   input wire logic [11:0] conv_diff,
   input wire logic [11:0] conv_upper,
   input wire logic [11:0] conv_mid,
   input wire logic [11:0] conv_lower,
   // Configuration towards the analog side
   output aicc_pkg::aicc_cfg_t cfg_out,
   output logic hold_pulse,
   // Result readout
   input wire logic res_rd,
   output logic res_valid,
   output aicc_pkg::aicc_sample_t res_data,
   output logic fifo_ready_flag
);
   aicc_pkg::aicc_cfg_t cw_reg;
   aicc_pkg::aicc_src_t src;
   aicc_pkg::aicc_sample_t smp_next, smp_reg, fifo_q;
   logic clk_d_reg, fall, convert, scan_chan_reg, push_reg, push_ready;
   logic [3:0] fill_reg;
   logic [9:0] rd_data_reg;
   logic hold_reg, ready_reg, valid_reg, fifo_valid, pop;
   logic [11:0] value;

   // Write decode: only address zero reaches this register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cw_reg <= aicc_pkg::CW0_RESET; // R10
      end else if (wr_strobe && wr_data[11:aicc_pkg::ADDR_LO] == aicc_pkg::ADDR_CW0) begin // R1 R11
         cw_reg <= wr_data[9:0]; // R7
      end
   end

   // Readback stays alive in power down
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= '0;
      end else if (cfg_rd) begin
         rd_data_reg <= cw_reg; // R7
      end
   end

   // Falling edge of the shared pin; pin taken as synchronous
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_d_reg <= 1'b0;
      end else begin
         clk_d_reg <= sample_clock_in;
      end
   end
   assign fall = clk_d_reg && !sample_clock_in;
   // Same edge serves as conversion clock or start; power down stops both
   assign convert = fall && !cw_reg.power_down_bit; // R3 R4 R6

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg <= 1'b0;
      end else begin
         hold_reg <= convert && cw_reg.single_mode; // R4
      end
   end

   // Test source selection
   always_comb begin
      case (cw_reg.test_sel) // R9
         2'h1: src = aicc_pkg::SRC_UPPER;
         2'h2: src = aicc_pkg::SRC_MID;
         2'h3: src = aicc_pkg::SRC_LOWER;
         default: src = aicc_pkg::SRC_NORMAL;
      endcase
   end

   // Input arrangement; reserved codes fall back to the positive input
   always_comb begin
      case (cw_reg.arrangement) // R8 R13
         aicc_pkg::ARR_NEG_SE: value = conv_neg;
         aicc_pkg::ARR_DIFF: value = conv_diff;
         aicc_pkg::ARR_SCAN: value = scan_chan_reg ? conv_neg : conv_pos;
         default: value = conv_pos;
      endcase
      case (src) // R9
         aicc_pkg::SRC_UPPER: value = conv_upper;
         aicc_pkg::SRC_MID: value = conv_mid;
         aicc_pkg::SRC_LOWER: value = conv_lower;
         default: value = value;
      endcase
      smp_next.chan = (cw_reg.arrangement == aicc_pkg::ARR_SCAN) ? scan_chan_reg : 1'b0;
      smp_next.value = value;
   end

   // Autoscan alternates inputs; a lost push when full drops the sample
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_chan_reg <= 1'b0;
         push_reg <= 1'b0;
         smp_reg <= '0;
      end else begin
         push_reg <= convert; // R3
         if (convert) begin
            smp_reg <= smp_next;
            scan_chan_reg <= (cw_reg.arrangement == aicc_pkg::ARR_SCAN) ? !scan_chan_reg : 1'b0; // R8
         end
      end
   end

   aicc_fifo #(
      .WIDTH($bits(aicc_pkg::aicc_sample_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .flush(fifo_flush),
      .in_valid(push_reg),
      .in_ready(push_ready),
      .in_data(smp_reg),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_q)
   );

   // Readout is registered; FIFO stays readable in power down
   assign pop = res_rd && fifo_valid && !valid_reg; // R7
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_reg <= 1'b0;
         res_data <= '0;
      end else begin
         valid_reg <= pop;
         if (pop) begin
            res_data <= fifo_q;
         end
      end
   end

   // Count written results against the trigger level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_reg <= '0;
         ready_reg <= 1'b0;
      end else if (fifo_flush) begin
         fill_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= 1'b0;
         if (push_reg && push_ready) begin
            if (fill_reg + 4'h1 >= trig_level) begin // R12 R5
               fill_reg <= '0;
               ready_reg <= 1'b1;
            end else begin
               fill_reg <= fill_reg + 4'h1;
            end
         end
      end
   end

   assign cfg_out = cw_reg; // R2 R6
   assign cfg_rd_data = rd_data_reg;
   assign hold_pulse = hold_reg;
   assign res_valid = valid_reg;
   assign fifo_ready_flag = ready_reg;

   a_wr_decode: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      wr_strobe && wr_data[11:10] == 2'h0 |=> cw_reg == $past(wr_data[9:0]))
      else $error("control word not written");
   a_wr_other: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
      wr_strobe && wr_data[11:10] != 2'h0 |=> $stable(cw_reg))
      else $error("foreign address changed control word");
   a_ref_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      wr_strobe && wr_data[11:10] == 2'h0 |=> cfg_out.ext_ref == $past(wr_data[0]))
      else $error("reference select wrong");
   sequence s_fall;
      $fell(sample_clock_in) && !cw_reg.power_down_bit;
   endsequence
   a_cont_push: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      s_fall ##0 !cw_reg.single_mode |=> push_reg)
      else $error("no push on falling conversion clock");
   a_start_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      s_fall ##0 cw_reg.single_mode |=> hold_pulse && push_reg)
      else $error("start edge did not hold");
   a_cont_nohold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      !cw_reg.single_mode |=> !hold_pulse)
      else $error("hold pulse in continuous mode");
   a_pd_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
      cw_reg.power_down_bit && $past(cw_reg.power_down_bit) |-> !hold_pulse)
      else $error("conversion while powered down");
   a_pd_nopush: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
      cw_reg.power_down_bit |=> !push_reg)
      else $error("result stored while powered down");
   a_pd_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      res_rd && fifo_valid && !valid_reg |=> res_valid)
      else $error("readout blocked");
   a_readback: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      cfg_rd |=> cfg_rd_data == $past(cw_reg))
      else $error("readback does not match control word");
   a_scan_alt: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      convert && cw_reg.arrangement == aicc_pkg::ARR_SCAN && $stable(cw_reg)
      |=> scan_chan_reg != $past(scan_chan_reg))
      else $error("autoscan did not alternate");
   sequence s_pick;
      convert && cw_reg.test_sel == 2'h0;
   endsequence
   a_pos_pick: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      s_pick ##0 cw_reg.arrangement == aicc_pkg::ARR_POS_SE |=> smp_reg.value == $past(conv_pos))
      else $error("positive input not used");
   a_neg_pick: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      s_pick ##0 cw_reg.arrangement == aicc_pkg::ARR_NEG_SE |=> smp_reg.value == $past(conv_neg))
      else $error("negative input not used");
   a_diff_pick: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      s_pick ##0 cw_reg.arrangement == aicc_pkg::ARR_DIFF |=> smp_reg.value == $past(conv_diff))
      else $error("differential input not used");
   a_test_upper: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
      convert && cw_reg.test_sel == 2'h1 |=> smp_reg.value == $past(conv_upper))
      else $error("upper test value not used");
   a_test_mid: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
      convert && cw_reg.test_sel == 2'h2 |=> smp_reg.value == $past(conv_mid))
      else $error("midpoint test value not used");
   a_test_lower: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
      convert && cw_reg.test_sel == 2'h3 |=> smp_reg.value == $past(conv_lower))
      else $error("lower test value not used");
   a_trig_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5 R12
      fifo_ready_flag |-> $past(push_reg) && $past(fill_reg) + 4'h1 >= $past(trig_level))
      else $error("ready flag without trigger");
endmodule // aicc_ctrl
`default_nettype wire

// [test/aicc_host.sv]
// Host model driving the parallel port of the control block
`timescale 1ns/10ps
`default_nettype none
module aicc_host (
   // Clock
   input wire logic ref_clk,
   // Port towards the device
   output logic wr_strobe,
   output logic [11:0] wr_data,
   output logic cfg_rd,
   output logic res_rd
);
   initial begin
      wr_strobe = 1'b0;
      wr_data = 12'h000;
      cfg_rd = 1'b0;
      res_rd = 1'b0;
   end
   // Address on the top lines, value below; reserved codes are never sent
   task automatic wr(input logic [1:0] a, input logic [9:0] v);
      wr_strobe <= 1'b1;
      wr_data <= {a, v};
      @(posedge ref_clk);
      wr_strobe <= 1'b0;
      wr_data <= ~{a, v};
      @(posedge ref_clk);
   endtask
   // Reads are spaced every other cycle
   task automatic rd(input logic c);
      if (c) cfg_rd <= 1'b1;
      else res_rd <= 1'b1;
      @(posedge ref_clk);
      cfg_rd <= 1'b0;
      res_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule // aicc_host
`default_nettype wire

// [test/tb.sv]
// Testbench for the input configuration control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] trig_level = 4'h1;
   logic fifo_flush = 1'b0;
   logic pin = 1'b0;
   logic [11:0] cv [6] = '{default: 12'h000};
   logic wr_strobe, cfg_rd, res_rd, hold_pulse, res_valid, fifo_ready_flag, sc = 1'b0;
   logic [11:0] wr_data;
   logic [9:0] cfg_rd_data, cw = 10'h020, v;
   logic [1:0] a;
   logic [13:0] e;
   logic [4:0] arr [3] = '{5'h00, 5'h01, 5'h04};
   aicc_pkg::aicc_cfg_t cfg_out;
   aicc_pkg::aicc_sample_t res_data;
   logic [13:0] q [$];
   int error_cnt = 0, n_tests = 0, n_hold = 0, exp_hold = 0, n_flag = 0, f0, lvl;
   always #10 ref_clk = ~ref_clk;
   aicc_host u_aicc_host (.ref_clk(ref_clk), .wr_strobe(wr_strobe), .wr_data(wr_data), .cfg_rd(cfg_rd),
      .res_rd(res_rd));
   aicc_ctrl #(.DEPTH(8)) u_aicc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .wr_strobe(wr_strobe),
      .wr_data(wr_data), .cfg_rd(cfg_rd), .cfg_rd_data(cfg_rd_data), .trig_level(trig_level),
      .fifo_flush(fifo_flush), .sample_clock_in(pin), .conv_pos(cv[0]), .conv_neg(cv[1]),
      .conv_diff(cv[2]), .conv_upper(cv[3]), .conv_mid(cv[4]), .conv_lower(cv[5]), .cfg_out(cfg_out),
      .hold_pulse(hold_pulse), .res_rd(res_rd), .res_valid(res_valid), .res_data(res_data),
      .fifo_ready_flag(fifo_ready_flag));
   task automatic chk(input logic [12:0] s, input logic [12:0] x);
      n_tests++;
      if (s !== x) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bit 13 marks results whose channel tag matters
   function automatic logic [13:0] expv();
      if (cw[9:8] != 2'h0) return {2'b00, cv[2 + cw[9:8]]};
      case (cw[7:3])
         5'h01: return {2'b00, cv[1]};
         5'h04: return {2'b00, cv[2]};
         5'h11: return {1'b1, sc, cv[sc]};
         default: return {2'b00, cv[0]};
      endcase
   endfunction
   // Converter values stay put until well after the push
   task automatic conv(input logic keep);
      cv[0] <= 12'($urandom);
      cv[1] <= 12'($urandom);
      cv[2] <= 12'($urandom);
      cv[3] <= 12'($urandom);
      cv[4] <= 12'($urandom);
      cv[5] <= 12'($urandom);
      pin <= 1'b1;
      @(posedge ref_clk);
      pin <= 1'b0;
      if (keep) q.push_back(expv());
      if (keep && cw[7:3] == 5'h11) sc = ~sc;
      if (keep && cw[1]) exp_hold++;
      repeat (4) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      if (res_valid === 1'b1) begin
         if (q.size() == 0) chk(1'b1, 1'b0);
         else begin
            e = q.pop_front();
            chk(e[13] ? 13'(res_data) : {1'b0, res_data.value}, e[12:0]);
         end
      end
      if (hold_pulse === 1'b1) n_hold++;
      if (fifo_ready_flag === 1'b1) n_flag++;
   end
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
   initial begin
      void'($urandom(39));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      u_aicc_host.rd(1'b1);
      chk(13'(cfg_rd_data), 13'h020);
      chk(13'(cfg_out), 13'h020);
      cw = 10'h088;
      u_aicc_host.wr(2'h0, cw);
      repeat (4) conv(1'b1);
      repeat (4) u_aicc_host.rd(1'b0);
      for (int k = 0; k < 8; k++) begin
         a = (k % 2) ? 2'($urandom) : 2'h0;
         v = {2'(k), arr[k % 3], 3'($urandom)};
         u_aicc_host.wr(a, v);
         if (a == 2'h0) cw = v;
         u_aicc_host.rd(1'b1);
         chk(13'(cfg_rd_data), 13'(cw));
         chk(13'(cfg_out), 13'(cw));
         repeat (2) conv(!cw[2]);
         repeat (2) u_aicc_host.rd(1'b0);
      end
      cw = 10'h002;
      u_aicc_host.wr(2'h0, cw);
      fifo_flush <= 1'b1;
      @(posedge ref_clk);
      fifo_flush <= 1'b0;
      lvl = $urandom_range(5, 2);
      trig_level <= 4'(lvl);
      @(posedge ref_clk);
      f0 = n_flag;
      repeat (lvl - 1) conv(1'b1);
      chk(13'(n_flag), 13'(f0));
      conv(1'b1);
      chk(13'(n_flag), 13'(f0 + 1));
      repeat (lvl) u_aicc_host.rd(1'b0);
      chk(13'(n_hold), 13'(exp_hold));
      cw = 10'h000;
      u_aicc_host.wr(2'h0, cw);
      for (int k = 0; k < 9; k++)
         conv(k < 8);
      cw = 10'h004;
      u_aicc_host.wr(2'h0, cw);
      repeat (9) u_aicc_host.rd(1'b0);
      chk(13'(q.size()), 13'h000);
      test_done();
   end
endmodule // tb
`default_nettype wire
